// >>> logic/snooze_acq_pkg.sv
// Purpose: Shared constants and types for the snooze acquisition sequencer
// Assumes: 100 MHz ref_clk, AXI4-Lite register access
// Notes:   Offsets are byte addresses of 32-bit words
package snooze_acq_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned ACQ_PERIOD_MIN  = 30;
   localparam int unsigned ALARM_PERIOD_HR = 24;
   localparam longint ACQ_PERIOD_CYC   = longint'(ACQ_PERIOD_MIN) * 60 * CLK_HZ;
   localparam longint ALARM_PERIOD_CYC = longint'(ALARM_PERIOD_HR) * 3600 * CLK_HZ;
   localparam int unsigned CH_A = 5;
   localparam int unsigned CH_B = 6;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_ST = 8'h08;
   localparam logic [7:0] OFS_IRQ_MK = 8'h0c;
   localparam logic [7:0] OFS_WPTR   = 8'h10;
   localparam logic [7:0] OFS_BUFRD  = 8'h14;
   localparam logic [7:0] OFS_BUFDAT = 8'h18;
   // Control bits
   localparam int unsigned CTRL_EN_TMR  = 0;
   localparam int unsigned CTRL_EN_SER  = 1;
   localparam int unsigned CTRL_EN_CONV = 2;
   localparam int unsigned CTRL_TX_DONE = 3;
   localparam int unsigned CTRL_ALM_SET = 4;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
   // Interrupt event bits
   localparam int unsigned EV_ACQ  = 0;
   localparam int unsigned EV_WAKE = 1;
   localparam int unsigned EV_TX   = 2;
   localparam int unsigned NUM_EV  = 3;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {MODE_STANDBY, MODE_SNOOZE, MODE_NORMAL} pwr_mode_t;
   typedef enum logic [2:0] {XF_IDLE, XF_SAVE, XF_CLRFLAG, XF_TRIG, XF_DUMMY} xfer_step_t;
endpackage

// >>> logic/snooze_acquisition_sequencer.sv
// Purpose: Low-power acquisition sequencer with AXI4-Lite registers
// Assumes: ref_clk 100 MHz, rst asynchronous active high
// Notes:   Long periods are parameters so simulation can shorten them
`timescale 1ns/100ps
module snooze_acquisition_sequencer #(
   parameter longint ACQ_CYC   = snooze_acq_pkg::ACQ_PERIOD_CYC,
   parameter longint ALARM_CYC = snooze_acq_pkg::ALARM_PERIOD_CYC,
   parameter int     DEPTH     = 16,
   parameter int     DW        = 12
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // AXI4-Lite slave
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Converter side
   input  wire logic [DW-1:0] conv_result_a,
   input  wire logic [DW-1:0] conv_result_b,
   input  wire logic          conv_busy,
   input  wire logic          conv_snooze_req,
   output logic               conv_start,
   // Serial side
   input  wire logic          serial_snooze_req,
   output logic               serial_tx_req,
   // Wake sources, button is a pin
   input  wire logic          button_pin,
   // Power state and interrupt
   output logic               snooze_req,
   output logic [1:0]         pwr_mode,
   output logic               irq
);
   localparam int AW = $clog2(DEPTH);
   // Readback index must not run past the buffer, so depth is a power of two
   if (DEPTH < 2 || DEPTH != (1 << AW) || DW > 16 || DW < 1 || ACQ_CYC < 4 ||
       ALARM_CYC < 4) begin : g_bad_param
      $error("snooze_acquisition_sequencer: unsupported parameters");
   end

   xfer_if xf ();
   snooze_acq_pkg::pwr_mode_t mode_r, mode_nxt;
   logic [63:0]   acq_cnt_r, alm_cnt_r;
   logic          tmr_flag_r, alm_flag_r, alm_wake_r, alm_armed_r;
   logic [31:0]   ctrl_r;
   localparam int NUM_EV_W = snooze_acq_pkg::NUM_EV;
   logic [NUM_EV_W-1:0] ist_r, imk_r;
   logic [AW-1:0] wptr_r, rdidx_r;
   logic [DW-1:0] buf_a [DEPTH];
   logic [DW-1:0] buf_b [DEPTH];
   logic [2:0]    btn_sync_r;
   logic          btn_lvl_r;
   logic          conv_start_r, serial_tx_r, snooze_r;
   logic          aw_got_r, w_got_r;
   logic [7:0]    awaddr_r;
   logic [31:0]   wdata_r;

   // Button pin synchroniser, change counts once stages two and three agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         btn_sync_r <= 3'h0;
         btn_lvl_r  <= 1'b0;
      end else begin
         btn_sync_r <= {btn_sync_r[1:0], button_pin};
         if (btn_sync_r[1] == btn_sync_r[2])
            btn_lvl_r <= btn_sync_r[2];
      end
   end
   wire btn_rise = btn_sync_r[1] & btn_sync_r[2] & ~btn_lvl_r;

   // Decoded events and enables
   wire en_tmr    = ctrl_r[snooze_acq_pkg::CTRL_EN_TMR];
   wire en_ser    = ctrl_r[snooze_acq_pkg::CTRL_EN_SER];
   wire en_conv   = ctrl_r[snooze_acq_pkg::CTRL_EN_CONV];
   wire acq_tick  = (acq_cnt_r == 64'(ACQ_CYC - 1));
   wire alm_tick  = (alm_cnt_r == 64'(ALARM_CYC - 1));
   wire wake_ev   = alm_flag_r | btn_rise;
   wire tmr_route = tmr_flag_r & en_tmr & ~xf.busy;
   wire ext_req   = (en_ser & serial_snooze_req) | (en_conv & conv_snooze_req);

   // Write channel decode
   wire wr_fire  = aw_got_r & w_got_r & ~s_axi_bvalid;
   wire wr_ctrl  = wr_fire && (awaddr_r == snooze_acq_pkg::OFS_CTRL);
   wire wr_imk   = wr_fire && (awaddr_r == snooze_acq_pkg::OFS_IRQ_MK);
   wire wr_bufrd = wr_fire && (awaddr_r == snooze_acq_pkg::OFS_BUFRD);
   wire wr_ok    = wr_ctrl | wr_imk | wr_bufrd;
   wire tx_done  = wr_ctrl & wdata_r[snooze_acq_pkg::CTRL_TX_DONE];
   wire alm_set  = wr_ctrl & wdata_r[snooze_acq_pkg::CTRL_ALM_SET];
   wire rd_fire  = s_axi_arvalid & s_axi_arready;
   wire rd_ist   = rd_fire && (s_axi_araddr == snooze_acq_pkg::OFS_IRQ_ST);

   // Interval timer and its compare-match flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acq_cnt_r  <= 64'h0;
         tmr_flag_r <= 1'b0;
      end else begin
         acq_cnt_r <= acq_tick ? 64'h0 : acq_cnt_r + 64'h1;
         if (acq_tick)
            tmr_flag_r <= 1'b1;
         else if (xf.clr_flag)
            tmr_flag_r <= 1'b0;
      end
   end

   // Calendar alarm; rearmed only by software after an alarm wake
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         alm_cnt_r   <= 64'h0;
         alm_flag_r  <= 1'b0;
         alm_armed_r <= 1'b1;
      end else begin
         alm_cnt_r  <= alm_tick ? 64'h0 : alm_cnt_r + 64'h1;
         alm_flag_r <= alm_tick & alm_armed_r;
         if (alm_set)
            alm_armed_r <= 1'b1;
         else if (alm_flag_r)
            alm_armed_r <= 1'b0;
      end
   end

   // Power mode control, wake has top priority
   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         snooze_acq_pkg::MODE_STANDBY:
            if (wake_ev)
               mode_nxt = snooze_acq_pkg::MODE_NORMAL;
            else if (tmr_route || ext_req || xf.busy)
               mode_nxt = snooze_acq_pkg::MODE_SNOOZE;
         snooze_acq_pkg::MODE_SNOOZE:
            if (wake_ev)
               mode_nxt = snooze_acq_pkg::MODE_NORMAL;
            else if (!xf.busy && !xf.start && !ext_req)
               mode_nxt = snooze_acq_pkg::MODE_STANDBY;
         snooze_acq_pkg::MODE_NORMAL:
            if (tx_done && (!alm_wake_r || alm_armed_r || alm_set))
               mode_nxt = snooze_acq_pkg::MODE_STANDBY;
         default: mode_nxt = snooze_acq_pkg::MODE_STANDBY;
      endcase
   end
   assign xf.start = (mode_r == snooze_acq_pkg::MODE_STANDBY) & ~wake_ev & tmr_route;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_r       <= snooze_acq_pkg::MODE_STANDBY;
         alm_wake_r   <= 1'b0;
         conv_start_r <= 1'b0;
         serial_tx_r  <= 1'b0;
         snooze_r     <= 1'b0;
      end else begin
         mode_r       <= mode_nxt;
         if (mode_r != snooze_acq_pkg::MODE_NORMAL && wake_ev)
            alm_wake_r <= alm_flag_r;
         conv_start_r <= xf.trig;
         serial_tx_r  <= (mode_nxt == snooze_acq_pkg::MODE_NORMAL);
         snooze_r     <= (mode_nxt == snooze_acq_pkg::MODE_SNOOZE);
      end
   end

   // Result buffers: one array per channel
   always_ff @(posedge ref_clk) begin
      if (xf.save_we) begin
         buf_a[wptr_r] <= conv_result_a;
         buf_b[wptr_r] <= conv_result_b;
      end
   end

   // Write position wraps at depth, overwriting the oldest entry
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         wptr_r <= '0;
      else if (tx_done)
         wptr_r <= '0;
      else if (xf.save_we)
         wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + AW'(1);
   end

   // Control, mask and readback index registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_r  <= snooze_acq_pkg::CTRL_RST;
         imk_r   <= '0;
         rdidx_r <= '0;
      end else begin
         if (wr_ctrl)
            ctrl_r <= {27'h0, 2'h0, wdata_r[2:0]};
         if (wr_imk)
            imk_r <= wdata_r[NUM_EV_W-1:0];
         if (wr_bufrd)
            rdidx_r <= wdata_r[AW-1:0];
      end
   end

   // Sticky events; a new event wins over the read clear
   wire [NUM_EV_W-1:0] ev_in = {tx_done, wake_ev, xf.clr_flag};
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         ist_r <= '0;
      else
         ist_r <= (rd_ist ? '0 : ist_r) | ev_in;
   end

   // AXI write address and data taken in either order
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         awaddr_r     <= 8'h0;
         wdata_r      <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= snooze_acq_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                      {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? snooze_acq_pkg::RESP_OKAY : snooze_acq_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
      end
   end

   // Read mux
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         snooze_acq_pkg::OFS_CTRL:   rd_mux = ctrl_r;
         snooze_acq_pkg::OFS_STATUS: rd_mux = {26'h0, alm_armed_r, tmr_flag_r,
                                               xf.busy, snooze_r, mode_r};
         snooze_acq_pkg::OFS_IRQ_ST: rd_mux = 32'(ist_r);
         snooze_acq_pkg::OFS_IRQ_MK: rd_mux = 32'(imk_r);
         snooze_acq_pkg::OFS_WPTR:   rd_mux = 32'(wptr_r);
         snooze_acq_pkg::OFS_BUFRD:  rd_mux = 32'(rdidx_r);
         snooze_acq_pkg::OFS_BUFDAT: rd_mux = {16'(buf_b[rdidx_r]), 16'(buf_a[rdidx_r])};
         default: begin
            rd_mux = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // One read at a time; arready only when no answer pending
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= snooze_acq_pkg::RESP_OKAY;
         irq           <= 1'b0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? snooze_acq_pkg::RESP_OKAY : snooze_acq_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         irq <= |(((rd_ist ? '0 : ist_r) | ev_in) & imk_r);
      end
   end

   assign conv_start    = conv_start_r;
   assign serial_tx_req = serial_tx_r;
   assign snooze_req    = snooze_r;
   assign pwr_mode      = mode_r;

   xfer_chain u_chain (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .conv_busy (conv_busy),
      .xf        (xf)
   );

   // Assertions
   property p_trig_after_save;
      @(posedge ref_clk) disable iff (rst) xf.save_we |=> xf.clr_flag ##1 xf.trig;
   endproperty
   a_trig_after_save: assert property (p_trig_after_save) else $error("chain order broken");
   property p_start_pulse;
      @(posedge ref_clk) disable iff (rst) xf.trig |=> conv_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("scan not started");
   property p_snooze_hold;
      @(posedge ref_clk) disable iff (rst)
         (xf.busy && mode_r != snooze_acq_pkg::MODE_NORMAL && !wake_ev) |=> snooze_req;
   endproperty
   a_snooze_hold: assert property (p_snooze_hold) else $error("snooze dropped early");
   property p_snooze_end;
      @(posedge ref_clk) disable iff (rst)
         (mode_r == snooze_acq_pkg::MODE_SNOOZE && !xf.busy && !xf.start && !ext_req && !wake_ev)
         |=> (mode_r == snooze_acq_pkg::MODE_STANDBY) && !snooze_req;
   endproperty
   a_snooze_end: assert property (p_snooze_end) else $error("no return to standby");
   property p_wake;
      @(posedge ref_clk) disable iff (rst)
         (wake_ev && mode_r != snooze_acq_pkg::MODE_NORMAL) |=> mode_r == snooze_acq_pkg::MODE_NORMAL;
   endproperty
   a_wake: assert property (p_wake) else $error("wake ignored");
   property p_ptr_reset;
      @(posedge ref_clk) disable iff (rst) tx_done |=> wptr_r == '0;
   endproperty
   a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not reset");
   property p_flag_clear;
      @(posedge ref_clk) disable iff (rst) (xf.clr_flag && !acq_tick) |=> !tmr_flag_r;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("timer flag kept");
   property p_standby_entry;
      @(posedge ref_clk) disable iff (rst)
         (mode_r == snooze_acq_pkg::MODE_STANDBY && !wake_ev && ext_req)
         |=> snooze_req ##1 (snooze_req || !ext_req || wake_ev);
   endproperty
   a_standby_entry: assert property (p_standby_entry) else $error("no snooze entry");
endmodule // snooze_acquisition_sequencer

// >>> logic/xfer_chain.sv
// Purpose: Chained transfer steps for one acquisition cycle
// Assumes: conv_busy is already synchronised
// Notes:   Dummy step lasts until the scan reports done
`timescale 1ns/100ps
module xfer_chain (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Converter state
   input  wire logic conv_busy,
   // Carrier
   xfer_if.chn       xf
);
   snooze_acq_pkg::xfer_step_t step_r, step_nxt;
   logic seen_busy_r;

   // Fixed order: save, clear, trigger, then dummy hold
   always_comb begin
      step_nxt = step_r;
      unique case (step_r)
         snooze_acq_pkg::XF_IDLE:    if (xf.start) step_nxt = snooze_acq_pkg::XF_SAVE;
         snooze_acq_pkg::XF_SAVE:    step_nxt = snooze_acq_pkg::XF_CLRFLAG;
         snooze_acq_pkg::XF_CLRFLAG: step_nxt = snooze_acq_pkg::XF_TRIG;
         snooze_acq_pkg::XF_TRIG:    step_nxt = snooze_acq_pkg::XF_DUMMY;
         snooze_acq_pkg::XF_DUMMY:   if (seen_busy_r && !conv_busy)
                                        step_nxt = snooze_acq_pkg::XF_IDLE;
         default:                    step_nxt = snooze_acq_pkg::XF_IDLE;
      endcase
   end

   assign xf.busy     = (step_r != snooze_acq_pkg::XF_IDLE);
   assign xf.save_we  = (step_r == snooze_acq_pkg::XF_SAVE);
   assign xf.clr_flag = (step_r == snooze_acq_pkg::XF_CLRFLAG);
   assign xf.trig     = (step_r == snooze_acq_pkg::XF_TRIG);

   // Busy seen guards against ending before the scan begins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         step_r      <= snooze_acq_pkg::XF_IDLE;
         seen_busy_r <= 1'b0;
      end else begin
         step_r      <= step_nxt;
         seen_busy_r <= (step_r == snooze_acq_pkg::XF_DUMMY) && (seen_busy_r || conv_busy);
      end
   end
endmodule // xfer_chain

// >>> logic/xfer_if.sv
// Purpose: Carrier between mode control and transfer chain
// Assumes: Single clock domain
// Notes:   Start is a one-cycle pulse, busy is a level
`timescale 1ns/100ps
interface xfer_if;
   logic start;
   logic busy;
   logic save_we;
   logic clr_flag;
   logic trig;
   modport ctl (output start, input busy, save_we, clr_flag, trig);
   modport chn (input start, output busy, save_we, clr_flag, trig);
endinterface // xfer_if

// >>> tb/conv_model.sv
// Purpose: Converter stand-in facing the acquisition sequencer
// Assumes: Same clock as the sequencer
// Notes:   Results change only when a scan ends, so a save sees the prior scan
`timescale 1ns/100ps
module conv_model #(
   parameter int DW   = 12,
   parameter int SCAN = 40
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // Converter link
   input  wire logic          conv_start,
   output logic               conv_busy,
   output logic [DW-1:0]      conv_result_a,
   output logic [DW-1:0]      conv_result_b
);
   logic [7:0]    left_r;
   logic [DW-1:0] scans_r;
   // Scan runs a fixed time after each trigger pulse
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         left_r  <= 8'h00;
         scans_r <= '0;
      end else if (conv_start) begin
         left_r <= 8'(SCAN);
      end else if (left_r != 8'h00) begin
         left_r <= left_r - 8'h01;
         if (left_r == 8'h01) begin
            scans_r <= scans_r + 1'b1;
         end
      end
   end
   // Distinct values per channel and scan, so a stale save shows
   assign conv_busy     = (left_r != 8'h00);
   assign conv_result_a = DW'(12'h100) + scans_r;
   assign conv_result_b = DW'(12'h200) + scans_r;
endmodule // conv_model

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the snooze acquisition sequencer
// Assumes: Short timer and alarm periods stand in for the long ones
// Notes:   Register access through AXI4-Lite tasks only
`timescale 1ns/100ps
module testbench;
   localparam int         ACQ   = 200;
   localparam int         LIMIT = 20000;
   localparam logic [1:0] STBY  = 2'(snooze_acq_pkg::MODE_STANDBY);
   localparam logic [1:0] SNZ   = 2'(snooze_acq_pkg::MODE_SNOOZE);
   localparam logic [1:0] NORM  = 2'(snooze_acq_pkg::MODE_NORMAL);
   logic ref_clk = 1'b0, rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, pwr_mode, wr_resp;
   logic [11:0] conv_result_a, conv_result_b;
   logic conv_busy, conv_start, serial_tx_req, snooze_req, irq;
   logic conv_snooze_req = 1'b0, serial_snooze_req = 1'b0, button_pin = 1'b0;
   int bad_count = 0, checked = 0, cycles = 0;
   // Sequencer with shortened periods
   snooze_acquisition_sequencer #(.ACQ_CYC(ACQ), .ALARM_CYC(5000)) dut (.*);
   // Converter on the far side
   conv_model #(.DW(12), .SCAN(40)) conv (
      .ref_clk(ref_clk), .rst(rst), .conv_start(conv_start), .conv_busy(conv_busy),
      .conv_result_a(conv_result_a), .conv_result_b(conv_result_b));
   always #5 ref_clk = ~ref_clk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         $display("[ERR] %0t run too long", $time);
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d & m, exp);
   endtask
   // Bounded wait for a power mode, then compare
   task automatic wait_mode(input logic [1:0] m, input int lim);
      for (int i = 0; i < lim && pwr_mode !== m; i++) @(posedge ref_clk);
      chk(32'(pwr_mode), 32'(m));
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic        held;
      longint      t0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rdchk(snooze_acq_pkg::OFS_CTRL, 32'hffffffff, snooze_acq_pkg::CTRL_RST);
      rd(8'h1c, d, r);
      chk(32'(r), 32'(snooze_acq_pkg::RESP_SLVERR));
      chk(d, 32'h0);
      wr(snooze_acq_pkg::OFS_STATUS, 32'h0);
      chk(32'(wr_resp), 32'(snooze_acq_pkg::RESP_SLVERR));
      $display("test reset done");
      // Each source alone, timer off so only one request is enabled
      for (int i = 0; i < 2; i++) begin
         wr(snooze_acq_pkg::OFS_CTRL, (i == 0) ? 32'h2 : 32'h4);
         serial_snooze_req <= (i == 0);
         conv_snooze_req   <= (i == 1);
         wait_mode(SNZ, 10);
         chk(32'(snooze_req), 32'h1);
         serial_snooze_req <= 1'b0;
         conv_snooze_req   <= 1'b0;
         wait_mode(STBY, 10);
      end
      $display("test sources done");
      // Two acquisition cycles, irq masked at first
      wr(snooze_acq_pkg::OFS_CTRL, 32'h1);
      for (int k = 0; k < 2; k++) begin
         wait_mode(SNZ, 300);
         if (k == 1) chk(32'(($time - t0) / 10), ACQ);
         t0 = $time;
         for (int i = 0; i < 20 && !conv_busy; i++) @(posedge ref_clk);
         rdchk(snooze_acq_pkg::OFS_STATUS, 32'h1f, 32'h0d);
         rdchk(snooze_acq_pkg::OFS_WPTR, 32'hffffffff, k + 1);
         held = 1'b1;
         for (int i = 0; i < 100 && conv_busy; i++) begin
            held = held & snooze_req;
            @(posedge ref_clk);
         end
         chk(32'(held), 32'h1);
         wait_mode(STBY, 10);
         chk(32'(snooze_req), 32'h0);
      end
      chk(32'(irq), 32'h0);
      wr(snooze_acq_pkg::OFS_IRQ_MK, 32'h7);
      chk(32'(wr_resp), 32'(snooze_acq_pkg::RESP_OKAY));
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h1);
      rdchk(snooze_acq_pkg::OFS_IRQ_ST, 32'h1, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0);
      for (int i = 0; i < 2; i++) begin
         wr(snooze_acq_pkg::OFS_BUFRD, i);
         rdchk(snooze_acq_pkg::OFS_BUFDAT, '1, {16'(12'h200 + i), 16'(12'h100 + i)});
      end
      $display("test acquisition done");
      // Button pressed while snoozing
      wait_mode(SNZ, 300);
      button_pin <= 1'b1;
      wait_mode(NORM, 20);
      chk(32'(serial_tx_req), 32'h1);
      button_pin <= 1'b0;
      rdchk(snooze_acq_pkg::OFS_IRQ_ST, 32'h2, 32'h2);
      wr(snooze_acq_pkg::OFS_CTRL, 32'h9);
      repeat (2) @(posedge ref_clk);
      chk(32'(pwr_mode !== NORM), 32'h1);
      rdchk(snooze_acq_pkg::OFS_WPTR, 32'hffffffff, 32'h0);
      $display("test button done");
      // Alarm wake needs re-arming before low power
      wait_mode(NORM, 6000);
      chk(32'(serial_tx_req), 32'h1);
      wr(snooze_acq_pkg::OFS_CTRL, 32'h9);
      repeat (2) @(posedge ref_clk);
      chk(32'(pwr_mode), 32'(NORM));
      wr(snooze_acq_pkg::OFS_CTRL, 32'h19);
      repeat (2) @(posedge ref_clk);
      chk(32'(pwr_mode !== NORM), 32'h1);
      rdchk(snooze_acq_pkg::OFS_STATUS, 32'h20, 32'h20);
      $display("test alarm done");
      conclude();
   end
endmodule // testbench
